/* File: logic/camd_decoder.v */
// addressing-mode decoder and effective-address former
`timescale 1ns/100ps
`include "camd_consts.vh"
module camd_decoder (
   clock,
   sys_rst,
   start,
   mode,
   ctl_op,
   halt_op,
   index_sel,
   index_x,
   index_y,
   rmw,
   irq,
   mem_req,
   mem_addr,
   mem_ack,
   mem_rdata,
   busy,
   done,
   mode_error,
   ea,
   operand,
   is_operand,
   length,
   int_mask,
   wait_state,
   halt_state
);
   input wire clock;
   input wire sys_rst;
   input wire start;
   input wire [3:0] mode;
   input wire [1:0] ctl_op;
   input wire halt_op;
   input wire index_sel;
   input wire [7:0] index_x;
   input wire [7:0] index_y;
   input wire rmw;
   input wire irq;
   output wire mem_req;
   output wire [15:0] mem_addr;
   input wire mem_ack;
   input wire [7:0] mem_rdata;
   output wire busy;
   output reg done;
   output reg mode_error;
   output reg [15:0] ea;
   output reg [7:0] operand;
   output reg is_operand;
   output reg [1:0] length;
   output reg [1:0] int_mask;
   output reg wait_state;
   output reg halt_state;

   localparam S_IDLE = 5'b00001;
   localparam S_B1 = 5'b00010;
   localparam S_B2 = 5'b00100;
   localparam S_P1 = 5'b01000;
   localparam S_P2 = 5'b10000;

   reg [4:0] state_q;
   reg [4:0] state_d;
   reg [3:0] mode_q;
   reg [7:0] idx_q;
   reg [7:0] b1_q;
   reg [15:0] pc_q;
   reg [7:0] ptr_hi_q;
   reg fetch_go;
   reg [15:0] fetch_addr;
   wire fetch_done;
   wire [7:0] fetch_data;
   wire [15:0] sum;
   reg [15:0] add_base;

   // ==========================================
   // mode classification
   function is_long;
      input [3:0] m;
      begin
         is_long = (m == `CAMD_M_DIR_L) || (m == `CAMD_M_IDX_L) ||
                   (m == `CAMD_M_IND_L) || (m == `CAMD_M_IIX_L);
      end
   endfunction

   function [1:0] bytes_after;
      input [3:0] m;
      begin
         case (m)
            `CAMD_M_INH, `CAMD_M_IDX_0: bytes_after = 2'h0;
            `CAMD_M_DIR_L, `CAMD_M_IDX_L: bytes_after = 2'h2;
            default: bytes_after = 2'h1;
         endcase
      end
   endfunction

   function is_indirect;
      input [3:0] m;
      begin
         is_indirect = (m == `CAMD_M_IND_S) || (m == `CAMD_M_IND_L) ||
                       (m == `CAMD_M_IIX_S) || (m == `CAMD_M_IIX_L);
      end
   endfunction

   function is_indexed;
      input [3:0] m;
      begin
         is_indexed = (m == `CAMD_M_IDX_S) || (m == `CAMD_M_IDX_L) ||
                      (m == `CAMD_M_IIX_S) || (m == `CAMD_M_IIX_L);
      end
   endfunction

   // a byte address inside page zero
   function [15:0] page0;
      input [7:0] lo;
      begin
         page0 = {`CAMD_PAGE0_HI, lo};
      end
   endfunction

   // ==========================================
   // shared fetch and adder
   camd_byte_fetch u_fetch (
      .clock(clock),
      .sys_rst(sys_rst),
      .go(fetch_go),
      .addr(fetch_addr),
      .mem_req(mem_req),
      .mem_addr(mem_addr),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata),
      .done(fetch_done),
      .data(fetch_data)
   );

   camd_ea_adder u_add (
      .base(add_base),
      .index(idx_q),
      .sum(sum)
   );

   assign busy = ~state_q[0];

   // ==========================================
   // fetch address and next state
   always @* begin
      state_d = state_q;
      fetch_go = 1'b0;
      fetch_addr = pc_q;
      case (state_q)
         S_IDLE: begin
         end
         S_B1: begin
            fetch_go = 1'b1;
            if (fetch_done) begin
               if (mode_q == `CAMD_M_DIR_L || mode_q == `CAMD_M_IDX_L)
                  state_d = S_B2;
               else if (is_indirect(mode_q))
                  state_d = S_P1;
               else
                  state_d = S_IDLE;
            end
         end
         S_B2: begin
            fetch_go = 1'b1;
            if (fetch_done)
               state_d = S_IDLE;
         end
         S_P1: begin
            // pointer lives in page zero at the address held in the byte after the opcode
            fetch_go = 1'b1;
            fetch_addr = page0(b1_q);
            if (fetch_done) begin
               if (mode_q == `CAMD_M_IND_L || mode_q == `CAMD_M_IIX_L)
                  state_d = S_P2;
               else
                  state_d = S_IDLE;
            end
         end
         S_P2: begin
            // low byte of a word pointer follows its high byte
            fetch_go = 1'b1;
            // pointer address wraps inside page zero
            fetch_addr = page0(b1_q + 8'h01);
            if (fetch_done)
               state_d = S_IDLE;
         end
         default: state_d = S_IDLE;
      endcase
      // the landed byte is consumed this cycle; the next read waits for the new state
      if (fetch_done)
         fetch_go = 1'b0;
   end

   // base operand for the adder, by the byte just received
   always @* begin
      add_base = page0(fetch_data);
      if (state_q == S_B2)
         add_base = {b1_q, fetch_data};
      if (state_q == S_P2)
         add_base = {ptr_hi_q, fetch_data};
   end

   // ==========================================
   // sequencing registers and results
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= S_IDLE;
         mode_q <= `CAMD_M_INH;
         idx_q <= 8'h00;
         b1_q <= 8'h00;
         ptr_hi_q <= 8'h00;
         pc_q <= 16'h0000;
         done <= 1'b0;
         mode_error <= 1'b0;
         ea <= 16'h0000;
         operand <= 8'h00;
         is_operand <= 1'b0;
         length <= 2'd0;
         int_mask <= `CAMD_MASK_LVL3;
         wait_state <= 1'b0;
         halt_state <= 1'b0;
      end else begin
         state_q <= state_d;
         done <= 1'b0;
         if (irq)
            wait_state <= 1'b0;
         if (state_q == S_IDLE && start && !wait_state && !halt_state) begin
            mode_q <= mode;
            idx_q <= index_sel ? index_y : index_x;
            length <= bytes_after(mode);
            is_operand <= (mode == `CAMD_M_IMM);
            mode_error <= 1'b0;
            if (mode > `CAMD_M_IIX_L) begin
               // unassigned codes get an error result instead of a silent byte fetch
               mode_error <= 1'b1;
               done <= 1'b1;
            end else if (rmw && is_long(mode)) begin
               // memory-to-memory forms exist only as short modes
               mode_error <= 1'b1;
               done <= 1'b1;
            end else if (mode == `CAMD_M_INH) begin
               done <= 1'b1;
               case (ctl_op)
                  `CAMD_OP_SET_MASK: int_mask <= `CAMD_MASK_LVL3;
                  `CAMD_OP_CLR_MASK: int_mask <= `CAMD_MASK_LVL0;
                  `CAMD_OP_WAIT: wait_state <= 1'b1;
                  default: int_mask <= int_mask;
               endcase
               if (halt_op)
                  halt_state <= 1'b1;
            end else if (mode == `CAMD_M_IDX_0) begin
               ea <= page0(index_sel ? index_y : index_x);
               done <= 1'b1;
            end else begin
               state_q <= S_B1;
            end
         end
         if (fetch_done) begin
            pc_q <= pc_q + 16'h0001;
            case (state_q)
               S_B1: begin
                  b1_q <= fetch_data;
                  if (mode_q == `CAMD_M_IMM) begin
                     operand <= fetch_data;
                     done <= 1'b1;
                  end else if (mode_q == `CAMD_M_DIR_S) begin
                     ea <= page0(fetch_data);
                     done <= 1'b1;
                  end else if (mode_q == `CAMD_M_IDX_S) begin
                     ea <= sum;
                     done <= 1'b1;
                  end
               end
               S_B2: begin
                  ea <= is_indexed(mode_q) ? sum : add_base;
                  done <= 1'b1;
               end
               S_P1: begin
                  pc_q <= pc_q;
                  if (mode_q == `CAMD_M_IND_S) begin
                     ea <= page0(fetch_data);
                     done <= 1'b1;
                  end else if (mode_q == `CAMD_M_IIX_S) begin
                     ea <= sum;
                     done <= 1'b1;
                  end else begin
                     // b1_q keeps the pointer address for the low-byte read
                     ptr_hi_q <= fetch_data;
                  end
               end
               S_P2: begin
                  pc_q <= pc_q;
                  ea <= is_indexed(mode_q) ? sum : add_base;
                  done <= 1'b1;
               end
               default: pc_q <= pc_q;
            endcase
         end
      end
   end
endmodule

/* File: shared/camd_consts.vh */
// constants for the cpu addressing-mode decoder
`ifndef CAMD_CONSTS_VH
`define CAMD_CONSTS_VH
// ==========================================
// addressing modes (mode input encoding)
`define CAMD_M_INH 4'h0
`define CAMD_M_IMM 4'h1
`define CAMD_M_DIR_S 4'h2
`define CAMD_M_DIR_L 4'h3
`define CAMD_M_IDX_0 4'h4
`define CAMD_M_IDX_S 4'h5
`define CAMD_M_IDX_L 4'h6
`define CAMD_M_IND_S 4'h7
`define CAMD_M_IND_L 4'h8
`define CAMD_M_IIX_S 4'h9
`define CAMD_M_IIX_L 4'hA
// ==========================================
// inherent control operations
`define CAMD_OP_NONE 2'h0
`define CAMD_OP_SET_MASK 2'h1
`define CAMD_OP_CLR_MASK 2'h2
`define CAMD_OP_WAIT 2'h3
`define CAMD_MASK_LVL3 2'h3
`define CAMD_MASK_LVL0 2'h0
`define CAMD_PAGE0_HI 8'h00
`endif

/* File: logic/camd_byte_fetch.v */
// one-byte memory read sequencer
`timescale 1ns/100ps
module camd_byte_fetch (
   clock,
   sys_rst,
   go,
   addr,
   mem_req,
   mem_addr,
   mem_ack,
   mem_rdata,
   done,
   data
);
   input wire clock;
   input wire sys_rst;
   input wire go;
   input wire [15:0] addr;
   output wire mem_req;
   output reg [15:0] mem_addr;
   input wire mem_ack;
   input wire [7:0] mem_rdata;
   output wire done;
   output reg [7:0] data;
   reg busy_q;
   reg done_q;
   // ==========================================
   // request held until the memory acknowledges; done follows one cycle later
   // so that the byte already stands in data when the user consumes it
   assign mem_req = busy_q;
   assign done = done_q;
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         mem_addr <= 16'h0000;
         data <= 8'h00;
      end else begin
         done_q <= busy_q & mem_ack;
         if (go && !busy_q) begin
            busy_q <= 1'b1;
            mem_addr <= addr;
         end else if (busy_q && mem_ack) begin
            busy_q <= 1'b0;
            data <= mem_rdata;
         end
      end
   end
endmodule

/* File: logic/camd_ea_adder.v */
// unsigned index plus base adder
`timescale 1ns/100ps
module camd_ea_adder (
   base,
   index,
   sum
);
   input wire [15:0] base;
   input wire [7:0] index;
   output wire [15:0] sum;
   // wraps at 64 Kbyte; short forms never exceed 1FE so no truncation there
   assign sum = base + {8'h00, index};
endmodule

/* File: testbench/camd_mem.sv */
// program and data memory model answering the decoder's byte reads
`timescale 1ns/100ps
module camd_mem (
   input wire logic clock,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   output logic mem_ack,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:65535];
   int wt = 0;
   initial mem_ack = 0;
   initial mem_rdata = 8'h00;
   always @(posedge clock) begin
      if (mem_req && !mem_ack && wt >= (slow ? 3 : 0)) begin
         mem_ack <= 1;
         mem_rdata <= mem[mem_addr];
         wt <= 0;
      end else begin
         mem_ack <= 0;
         // data is only valid with ack: keep it moving so stale bytes show
         mem_rdata <= ~mem_rdata;
         wt <= mem_req ? wt + 1 : 0;
      end
   end
endmodule

/* File: testbench/camd_decoder_sva.sv */
// assertion checker bound to the addressing-mode decoder
`timescale 1ns/100ps
`include "camd_consts.vh"
module camd_decoder_sva (
   input wire clock,
   input wire sys_rst,
   input wire start,
   input wire [3:0] mode,
   input wire [1:0] ctl_op,
   input wire rmw,
   input wire irq,
   input wire mem_req,
   input wire busy,
   input wire done,
   input wire mode_error,
   input wire [15:0] ea,
   input wire is_operand,
   input wire [1:0] length,
   input wire [1:0] int_mask,
   input wire wait_state,
   input wire halt_state
);
   wire taken;
   reg [3:0] tk_mode_q;
   assign taken = start && !busy && !wait_state && !halt_state;
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tk_mode_q <= 4'h0;
      end else if (taken) begin
         tk_mode_q <= mode;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   done_bound_a: assert property (
      taken && mode != `CAMD_M_INH |-> ##[1:200] done) else $error("decode did not finish");
   mask_set_a: assert property (
      taken && mode == `CAMD_M_INH && ctl_op == `CAMD_OP_SET_MASK |-> ##[1:2] int_mask == 2'h3)
      else $error("mask not raised");
   mask_clr_a: assert property (
      taken && mode == `CAMD_M_INH && ctl_op == `CAMD_OP_CLR_MASK |-> ##[1:2] int_mask == 2'h0)
      else $error("mask not lowered");
   rmw_long_a: assert property (
      taken && rmw && (mode == `CAMD_M_DIR_L || mode == `CAMD_M_IDX_L ||
      mode == `CAMD_M_IND_L || mode == `CAMD_M_IIX_L)
      |-> ##[1:2] done && mode_error) else $error("long rmw not refused");
   imm_len_a: assert property (
      done && tk_mode_q == `CAMD_M_IMM |-> is_operand && length == 2'h1) else $error("immediate");
   dir_page_a: assert property (
      done && tk_mode_q == `CAMD_M_DIR_S |-> ea[15:8] == 8'h00 && length == 2'h1)
      else $error("short direct off page zero");
   idx_none_a: assert property (
      done && tk_mode_q == `CAMD_M_IDX_0 |-> ea[15:8] == 8'h00 && length == 2'h0)
      else $error("no-offset index");
   idx_short_a: assert property (
      done && tk_mode_q == `CAMD_M_IDX_S |-> ea <= 16'h01FE && length == 2'h1)
      else $error("short index range");
   ind_short_a: assert property (
      done && tk_mode_q == `CAMD_M_IND_S |-> ea[15:8] == 8'h00) else $error("short indirect");
   long_len_a: assert property (
      done && !mode_error && (tk_mode_q == `CAMD_M_DIR_L || tk_mode_q == `CAMD_M_IDX_L)
      |-> length == 2'h2) else $error("long length");
   wait_exit_a: assert property (
      wait_state && irq |=> !wait_state) else $error("wait not left on interrupt");
   halt_hold_a: assert property (
      halt_state |=> halt_state) else $error("halt left without reset");
   inh_one_a: assert property (
      taken && mode == `CAMD_M_INH |=> done && !busy && length == 2'h0)
      else $error("inherent not finished in one cycle");
   fetch_busy_a: assert property (
      mem_req |-> busy) else $error("memory read outside a decode");
   cover property (done && mode_error);
   cover property (done && tk_mode_q == `CAMD_M_IIX_L);
   cover property (wait_state && irq);
endmodule
bind camd_decoder camd_decoder_sva u_sva (.clock(clock), .sys_rst(sys_rst), .start(start),
   .mode(mode), .ctl_op(ctl_op), .rmw(rmw), .irq(irq), .mem_req(mem_req), .busy(busy),
   .done(done), .mode_error(mode_error), .ea(ea), .is_operand(is_operand), .length(length),
   .int_mask(int_mask), .wait_state(wait_state), .halt_state(halt_state));

/* File: testbench/tb.sv */
// self-checking testbench for the addressing-mode decoder
`timescale 1ns/100ps
`include "camd_consts.vh"
module tb;
   logic clock = 0, sys_rst = 1, start = 0, halt_op = 0, index_sel = 0, rmw = 0, irq = 0;
   logic slow = 0, mem_req, mem_ack, busy, done, mode_error, is_operand, wait_state, halt_state;
   logic [3:0] mode = 4'h0;
   logic [1:0] ctl_op = 2'h0, length, int_mask;
   logic [7:0] index_x = 8'h00, index_y = 8'h00, mem_rdata, operand;
   logic [15:0] mem_addr, ea;
   int n_fail = 0, n_compared = 0, pc = 0, cyc = 0, k;
   always #25 clock = ~clock;
   camd_decoder u_dut (.clock(clock), .sys_rst(sys_rst), .start(start), .mode(mode),
      .ctl_op(ctl_op), .halt_op(halt_op), .index_sel(index_sel), .index_x(index_x),
      .index_y(index_y), .rmw(rmw), .irq(irq), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done),
      .mode_error(mode_error), .ea(ea), .operand(operand), .is_operand(is_operand),
      .length(length), .int_mask(int_mask), .wait_state(wait_state),
      .halt_state(halt_state));
   camd_mem u_mem (.clock(clock), .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   task print_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   task chk_ea(string nm, logic [15:0] e, logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_fld(string nm, logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic int mb(int a);
      return u_mem.mem[a % 65536];
   endfunction
   task automatic run(logic [3:0] m, logic r, logic [1:0] op, logic h);
      logic s;
      logic [7:0] ix, iy;
      int x, b, w, l, base, e, n, bad;
      s = $urandom;
      ix = $urandom;
      iy = $urandom;
      x = s ? iy : ix;
      @(posedge clock);
      {start, mode, rmw, ctl_op, halt_op, index_sel} <= {1'b1, m, r, op, h, s};
      {index_x, index_y, slow} <= {ix, iy, 1'($urandom)};
      @(posedge clock);
      start <= 0;
      #1;
      for (n = 0; n < 60 && done !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      chk_fld("done", 1, done);
      b = mb(pc);
      w = b * 256 + mb(pc + 1);
      l = (m == `CAMD_M_INH || m == `CAMD_M_IDX_0) ? 0 : 1;
      if (m == `CAMD_M_DIR_L || m == `CAMD_M_IDX_L) l = 2;
      base = (l == 2) ? w : (l == 1) ? b : 0;
      if (m == `CAMD_M_IND_S || m == `CAMD_M_IIX_S) base = mb(b);
      if (m == `CAMD_M_IND_L || m == `CAMD_M_IIX_L) base = mb(b) * 256 + mb((b + 1) % 256);
      if ((m >= `CAMD_M_IDX_0 && m <= `CAMD_M_IDX_L) || m >= `CAMD_M_IIX_S) base += x;
      e = base % 65536;
      bad = (m > `CAMD_M_IIX_L) || (r && (l == 2 || m == `CAMD_M_IND_L || m == `CAMD_M_IIX_L));
      if (bad) begin
         chk_fld("mode_error", 1, mode_error);
      end else begin
         chk_fld("mode_error", 0, mode_error);
         chk_fld("length", l, length);
         chk_fld("is_operand", m == `CAMD_M_IMM, is_operand);
         if (m == `CAMD_M_IMM) chk_fld("operand", b, operand);
         if (m > `CAMD_M_IMM) chk_ea("ea", e, ea);
         pc = (pc + l) % 65536;
      end
   endtask
   initial begin
      void'($urandom(63640));
      for (int i = 0; i < 65536; i++) u_mem.mem[i] = $urandom;
      repeat (10) @(posedge clock);
      sys_rst <= 0;
      chk_fld("int_mask", 3, int_mask);
      for (k = 0; k < 66; k++) run(k % 11, 0, `CAMD_OP_NONE, 0);
      $display("test modes done");
      run(`CAMD_M_DIR_L, 1, `CAMD_OP_NONE, 0);
      run(`CAMD_M_IDX_L, 1, `CAMD_OP_NONE, 0);
      run(`CAMD_M_IDX_S, 1, `CAMD_OP_NONE, 0);
      run(`CAMD_M_IND_L, 1, `CAMD_OP_NONE, 0);
      run(`CAMD_M_IIX_L, 1, `CAMD_OP_NONE, 0);
      run(4'hB, 0, `CAMD_OP_NONE, 0);
      $display("test rmw done");
      run(`CAMD_M_INH, 0, `CAMD_OP_CLR_MASK, 0);
      chk_fld("int_mask", 0, int_mask);
      run(`CAMD_M_INH, 0, `CAMD_OP_SET_MASK, 0);
      chk_fld("int_mask", 3, int_mask);
      run(`CAMD_M_INH, 0, `CAMD_OP_WAIT, 0);
      chk_fld("wait_state", 1, wait_state);
      @(posedge clock);
      irq <= 1;
      @(posedge clock);
      irq <= 0;
      #1;
      chk_fld("wait_state", 0, wait_state);
      $display("test control done");
      run(`CAMD_M_INH, 0, `CAMD_OP_NONE, 1);
      chk_fld("halt_state", 1, halt_state);
      k = 0;
      @(posedge clock);
      start <= 1;
      repeat (4) begin
         @(posedge clock);
         #1;
         if (done === 1'b1) k++;
      end
      chk_fld("refused", 0, k);
      @(posedge clock);
      start <= 0;
      sys_rst <= 1;
      @(posedge clock);
      sys_rst <= 0;
      #1;
      chk_fld("halt_state", 0, halt_state);
      pc = 0;
      run(`CAMD_M_DIR_L, 0, `CAMD_OP_NONE, 0);
      $display("test halt done");
      print_verdict();
   end
endmodule
